// [src_fault_pkg.sv]
package src_fault_pkg;

	// ----------------------------------------------------------------
	// Clock and interval figures
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25000000;                // mclk rate
	localparam int CLK_PER_US = CLK_HZ / 1000000;    // Cycles per us
	localparam int OV_DEBOUNCE_US = 16;              // Overvoltage debounce
	localparam int UV_DEBOUNCE_US = 32;              // Undervoltage debounce
	localparam int OV_BLANK_US = 100;                // Overvoltage blanking
	localparam int AUTO_RESTART_MS = 2000;           // Auto-restart interval
	localparam logic [15:0] OV_DEB_RST = 16'(OV_DEBOUNCE_US * CLK_PER_US);
	localparam logic [15:0] UV_DEB_RST = 16'(UV_DEBOUNCE_US * CLK_PER_US);
	localparam logic [15:0] OV_BLANK_RST = 16'(OV_BLANK_US * CLK_PER_US);
	localparam logic [31:0] RESTART_CYCLES =
		32'(AUTO_RESTART_MS * (CLK_HZ / 1000));

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_VARIANT = 5'h00;  // Part variant select
	localparam logic [4:0] REG_OV_DEB = 5'h04;   // Overvoltage debounce count
	localparam logic [4:0] REG_UV_DEB = 5'h08;   // Undervoltage debounce count
	localparam logic [4:0] REG_OV_BLANK = 5'h0c; // Blanking count
	localparam logic [4:0] REG_RESTART = 5'h10;  // Auto-restart count
	localparam logic [4:0] REG_VMAX = 5'h14;     // Output voltage limit
	localparam logic [4:0] REG_STATUS = 5'h18;   // Live status
	localparam logic [4:0] REG_HIST = 5'h1c;     // Sticky fault history

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int ST_FAULT_LSB = 0;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_BUDGET_LSB = 12;
	localparam int ST_SEL_LSB = 20;

	// ----------------------------------------------------------------
	// Fault bit positions
	// ----------------------------------------------------------------
	localparam int NUM_FAULTS = 7;
	localparam int FB_OV = 0;     // Output overvoltage
	localparam int FB_UV = 1;     // Output undervoltage
	localparam int FB_OC = 2;     // Overcurrent
	localparam int FB_IOT = 3;    // Internal over-temperature
	localparam int FB_EOT = 4;    // External over-temperature
	localparam int FB_CC = 5;     // CC pin overvoltage
	localparam int FB_VCONN = 6;  // Cable supply overcurrent

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		VAR_ADJUST = 2'b00,  // Small package, adjustable power
		VAR_SMALL = 2'b01,   // Small package, fixed full power
		VAR_LARGE = 2'b10    // Large package, halving pin
	} variant_t;
	localparam logic [1:0] VARIANT_RST = 2'h0;

	typedef enum logic [1:0] {
		ST_ATTACHED = 2'b00,
		ST_FAULTED = 2'b01,
		ST_RESTART = 2'b10
	} prot_state_t;

	// ----------------------------------------------------------------
	// Voltages in 10 mV units
	// ----------------------------------------------------------------
	localparam logic [15:0] VSAFE_5V = 16'h01f4;  // 5 V reattach level
	localparam logic [15:0] VMAX_RST = 16'h0800;  // Default limit

	// ----------------------------------------------------------------
	// Power tables, indexed by select code
	// ----------------------------------------------------------------
	localparam logic [2:0] FULL_SEL = 3'h7;  // 60 W code
	localparam logic [2:0] HALF_SEL = 3'h3;  // 30 W code
	// Budget in 0.5 W units
	localparam logic [6:0] BUDGET_TABLE [0:7] = '{
		7'h20, 7'h20, 7'h2d, 7'h3c, 7'h4b, 7'h5a, 7'h69, 7'h78};
	// Currents in 10 mA units {5V, 9V, 12V, 15V, 20V}, zero = dropped
	localparam logic [44:0] CUR_TABLE [0:7] = '{
		{9'h12c, 9'h0b1, 9'h085, 9'h000, 9'h000},
		{9'h12c, 9'h0b1, 9'h085, 9'h000, 9'h000},
		{9'h12c, 9'h0f4, 9'h0b7, 9'h000, 9'h000},
		{9'h12c, 9'h12c, 9'h0fa, 9'h0c8, 9'h000},
		{9'h12c, 9'h12c, 9'h12c, 9'h0f6, 9'h000},
		{9'h12c, 9'h12c, 9'h12c, 9'h12c, 9'h0e1},
		{9'h12c, 9'h12c, 9'h12c, 9'h12c, 9'h104},
		{9'h12c, 9'h12c, 9'h12c, 9'h12c, 9'h12c}};

endpackage

// [source_fault_and_power_select.sv]
`timescale 1ns/1ps
// Overview of operation
// - Adjustable variant scales budget 16 W to 60 W
// - Select pins decode to seven budget levels
// - Lower levels drop or derate high PDOs
// - Large package top pin halves budget
// - Other small variants always advertise full power
// - Sample pins at power-on, soft, hard reset
// - Recovery from protection re-evaluates select pins
// - Seven fault sources are monitored
// - Output compared divided by ten, scaled thresholds
// - Faults except cable supply drop CC, switch
// - Fault clear starts restart timer, reattach 5 V
// - Overvoltage above 120% for debounce raises fault
// - Overvoltage blanked during voltage transitions
// - Requested voltage clamped to maximum limit
// - Under 65% beyond debounce raises undervoltage
// - No alert sent for undervoltage
// - PPS contract current limit suppresses percentage trip
// - Below minimum while attached always raises undervoltage
// - Minimum trip holds until latch release level
module source_fault_and_power_select #(
	parameter logic [31:0] RESTART_CYCLES = src_fault_pkg::RESTART_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Power select pins
	input wire logic powerSelBit0,
	input wire logic powerSelBit1,
	input wire logic powerSelBit2,
	// Reset events from the message engine
	input wire logic softReset,
	input wire logic hardReset,
	// Comparator flags, output sensed through divide-by-ten
	input wire logic vccAboveOvp,
	input wire logic vccBelowUvp,
	input wire logic vccBelowMin,
	input wire logic vccBelowLatch,
	input wire logic overCurrent,
	input wire logic intOverTemp,
	input wire logic thermistorOverTemp,
	input wire logic ccPinOverVoltage,
	input wire logic cableSupplyOverCurrent,
	// Contract context
	input wire logic voltageTransition,
	input wire logic ppsContract,
	input wire logic currentLimitActive,
	input wire logic [15:0] voltageRequest,
	// Outputs
	output logic [6:0] advertisedPowerBudget,
	output logic [8:0] pdoCurrent5v,
	output logic [8:0] pdoCurrent9v,
	output logic [8:0] pdoCurrent12v,
	output logic [8:0] pdoCurrent15v,
	output logic [8:0] pdoCurrent20v,
	output logic capsSend,
	output logic ccPullUpEn,
	output logic loadSwitchEn,
	output logic [15:0] voltageTarget,
	output logic reattach,
	output logic faultAlert,
	output logic cableSupplyOff
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	src_fault_pkg::variant_t variant;        // Part variant
	src_fault_pkg::prot_state_t state;       // Protection state
	logic [15:0] ovDebTerm;                  // Overvoltage debounce count
	logic [15:0] uvDebTerm;                  // Undervoltage debounce count
	logic [15:0] ovBlankTerm;                // Blanking count
	logic [31:0] restartTerm;                // Auto-restart count
	logic [15:0] vmax;                       // Output voltage limit
	logic [6:0] faultHist;                   // Sticky history
	logic [2:0] selLatched;                  // Sampled select pins
	logic [2:0] effSel;                      // Table index used
	logic powerOnDone;                       // First sample taken
	logic sampleNow;                         // Sample event
	logic sampleDly;                         // Sample event, one cycle late
	logic restartDone;                       // Timer expiry
	logic [15:0] ovCnt;                      // Overvoltage debounce
	logic [15:0] uvCnt;                      // Undervoltage debounce
	logic [15:0] blankCnt;                   // Blanking remaining
	logic [31:0] restartCnt;                 // Restart progress
	logic blanking;                          // Overvoltage masked
	logic ovRaw;                             // Overvoltage qualified
	logic uvRaw;                             // Percentage trip qualified
	logic ovFault;                           // Debounced overvoltage
	logic uvFault;                           // Debounced undervoltage
	logic uvMinLatch;                        // Below-minimum latch
	logic [6:0] faultPresent;                // Live fault vector
	logic protFault;                         // Any disconnecting fault
	logic wbReq;                             // Bus request pending
	logic wbWrite;                           // Write takes effect
	logic [31:0] rdData;                     // Read mux

	// Byte-lane merge for writes
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	assign wbReq = cyc_i & stb_i;
	assign wbWrite = wbReq & we_i & ack_o;

	// Acknowledge one cycle after request, drop the cycle after
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= wbReq & ~ack_o;
		end
	end

	// Read data mux, unmapped reads give zero
	always_comb begin
		rdData = 32'h0000_0000;
		unique case (adr_i)
			src_fault_pkg::REG_VARIANT: rdData[1:0] = variant;
			src_fault_pkg::REG_OV_DEB: rdData[15:0] = ovDebTerm;
			src_fault_pkg::REG_UV_DEB: rdData[15:0] = uvDebTerm;
			src_fault_pkg::REG_OV_BLANK: rdData[15:0] = ovBlankTerm;
			src_fault_pkg::REG_RESTART: rdData = restartTerm;
			src_fault_pkg::REG_VMAX: rdData[15:0] = vmax;
			src_fault_pkg::REG_STATUS: begin
				rdData[src_fault_pkg::ST_FAULT_LSB +: 7] = faultPresent;
				rdData[src_fault_pkg::ST_STATE_LSB +: 2] = state;
				rdData[src_fault_pkg::ST_BUDGET_LSB +: 7] =
					advertisedPowerBudget;
				rdData[src_fault_pkg::ST_SEL_LSB +: 3] = selLatched;
			end
			src_fault_pkg::REG_HIST: rdData[6:0] = faultHist;
			default: rdData = 32'h0000_0000;
		endcase
	end

	// Read data registered alongside ack
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dat_o <= 32'h0000_0000;
		end else if (wbReq & ~ack_o) begin
			dat_o <= rdData;
		end
	end

	// Configuration registers
	always_ff @(posedge mclk) begin
		logic [31:0] m;
		m = laneMerge(32'h0000_0000, dat_i, sel_i);
		if (!rst_n) begin
			variant <= src_fault_pkg::variant_t'(src_fault_pkg::VARIANT_RST);
			ovDebTerm <= src_fault_pkg::OV_DEB_RST;
			uvDebTerm <= src_fault_pkg::UV_DEB_RST;
			ovBlankTerm <= src_fault_pkg::OV_BLANK_RST;
			restartTerm <= RESTART_CYCLES;
			vmax <= src_fault_pkg::VMAX_RST;
		end else if (wbWrite) begin
			m = laneMerge(rdData, dat_i, sel_i);
			unique case (adr_i)
				src_fault_pkg::REG_VARIANT:
					variant <= src_fault_pkg::variant_t'(m[1:0]);
				src_fault_pkg::REG_OV_DEB: ovDebTerm <= m[15:0];
				src_fault_pkg::REG_UV_DEB: uvDebTerm <= m[15:0];
				src_fault_pkg::REG_OV_BLANK: ovBlankTerm <= m[15:0];
				src_fault_pkg::REG_RESTART: restartTerm <= m;
				src_fault_pkg::REG_VMAX: vmax <= m[15:0];
				default: ;
			endcase
		end
	end

	// Fault history, set wins over write-one-to-clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			faultHist <= 7'h00;
		end else begin
			if (wbWrite && adr_i == src_fault_pkg::REG_HIST && sel_i[0]) begin
				faultHist <= (faultHist & ~dat_i[6:0]) | faultPresent;
			end else begin
				faultHist <= faultHist | faultPresent;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power selection
	// ----------------------------------------------------------------
	assign sampleNow = ~powerOnDone | softReset | hardReset | restartDone;

	// Sample pins at power-on, resets and recovery
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			powerOnDone <= 1'b0;
			selLatched <= 3'h0;
		end else if (sampleNow) begin
			powerOnDone <= 1'b1;
			selLatched <= {powerSelBit2, powerSelBit1, powerSelBit0};
		end
	end

	// Table index from variant and sampled pins
	always_comb begin
		unique case (variant)
			src_fault_pkg::VAR_ADJUST: effSel = selLatched;
			src_fault_pkg::VAR_LARGE: effSel = selLatched[2] ?
				src_fault_pkg::HALF_SEL : src_fault_pkg::FULL_SEL;
			default: effSel = src_fault_pkg::FULL_SEL;
		endcase
	end

	// Advertised budget and PDO currents, announced one cycle later
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			advertisedPowerBudget <= 7'h00;
			{pdoCurrent5v, pdoCurrent9v, pdoCurrent12v, pdoCurrent15v,
				pdoCurrent20v} <= 45'h0;
			capsSend <= 1'b0;
			sampleDly <= 1'b0;
		end else begin
			// Offer goes out once the budget below has settled
			sampleDly <= sampleNow;
			capsSend <= sampleDly;
			advertisedPowerBudget <= src_fault_pkg::BUDGET_TABLE[effSel];
			{pdoCurrent5v, pdoCurrent9v, pdoCurrent12v, pdoCurrent15v,
				pdoCurrent20v} <= src_fault_pkg::CUR_TABLE[effSel];
		end
	end

	// ----------------------------------------------------------------
	// Overvoltage detection
	// ----------------------------------------------------------------
	assign blanking = voltageTransition | (blankCnt != 16'h0000);
	assign ovRaw = vccAboveOvp & ~blanking;

	// Blanking window reloads on each transition
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			blankCnt <= 16'h0000;
		end else if (voltageTransition) begin
			blankCnt <= ovBlankTerm;
		end else if (blankCnt != 16'h0000) begin
			blankCnt <= blankCnt - 16'h0001;
		end
	end

	// Debounce above 120% of the request
	always_ff @(posedge mclk) begin
		if (!rst_n || !ovRaw) begin
			ovCnt <= 16'h0000;
			ovFault <= 1'b0;
		end else if (ovCnt >= ovDebTerm) begin
			ovFault <= 1'b1;
		end else begin
			ovCnt <= ovCnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Undervoltage detection
	// ----------------------------------------------------------------
	assign uvRaw = vccBelowUvp & ~(ppsContract & currentLimitActive);

	// Debounce below 65% of the request
	always_ff @(posedge mclk) begin
		if (!rst_n || !uvRaw) begin
			uvCnt <= 16'h0000;
			uvFault <= 1'b0;
		end else if (uvCnt >= uvDebTerm) begin
			uvFault <= 1'b1;
		end else begin
			uvCnt <= uvCnt + 16'h0001;
		end
	end

	// Below-minimum trip holds until release level is reached
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			uvMinLatch <= 1'b0;
		end else if (vccBelowMin && state == src_fault_pkg::ST_ATTACHED) begin
			uvMinLatch <= 1'b1;
		end else if (vccBelowLatch) begin
			uvMinLatch <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Fault collection
	// ----------------------------------------------------------------
	always_comb begin
		faultPresent = 7'h00;
		faultPresent[src_fault_pkg::FB_OV] = ovFault;
		faultPresent[src_fault_pkg::FB_UV] = uvFault | uvMinLatch |
			(vccBelowMin & (state == src_fault_pkg::ST_ATTACHED));
		faultPresent[src_fault_pkg::FB_OC] = overCurrent;
		faultPresent[src_fault_pkg::FB_IOT] = intOverTemp;
		faultPresent[src_fault_pkg::FB_EOT] = thermistorOverTemp &
			(variant == src_fault_pkg::VAR_LARGE);
		faultPresent[src_fault_pkg::FB_CC] = ccPinOverVoltage;
		faultPresent[src_fault_pkg::FB_VCONN] = cableSupplyOverCurrent;
	end
	assign protFault = |faultPresent[src_fault_pkg::FB_CC:0];
	assign restartDone = (state == src_fault_pkg::ST_RESTART) & ~protFault &
		(restartCnt + 32'h1 >= restartTerm);

	// ----------------------------------------------------------------
	// Protection state machine
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= src_fault_pkg::ST_ATTACHED;
			restartCnt <= 32'h0;
		end else begin
			unique case (state)
				src_fault_pkg::ST_ATTACHED: begin
					restartCnt <= 32'h0;
					if (protFault) begin
						state <= src_fault_pkg::ST_FAULTED;
					end
				end
				src_fault_pkg::ST_FAULTED: begin
					restartCnt <= 32'h0;
					if (!protFault) begin
						state <= src_fault_pkg::ST_RESTART;
					end
				end
				src_fault_pkg::ST_RESTART: begin
					restartCnt <= restartCnt + 32'h1;
					if (protFault) begin
						state <= src_fault_pkg::ST_FAULTED;
					end else if (restartDone) begin
						state <= src_fault_pkg::ST_ATTACHED;
					end
				end
				default: state <= src_fault_pkg::ST_FAULTED;
			endcase
		end
	end

	// Connection outputs, alert and voltage target
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ccPullUpEn <= 1'b0;
			loadSwitchEn <= 1'b0;
			reattach <= 1'b0;
			faultAlert <= 1'b0;
			voltageTarget <= src_fault_pkg::VSAFE_5V;
		end else begin
			ccPullUpEn <= (state == src_fault_pkg::ST_ATTACHED) & ~protFault;
			loadSwitchEn <= (state == src_fault_pkg::ST_ATTACHED) & ~protFault;
			reattach <= restartDone;
			faultAlert <= (state == src_fault_pkg::ST_ATTACHED) & protFault &
				(|(faultPresent[src_fault_pkg::FB_CC:0] &
				~(6'h1 << src_fault_pkg::FB_UV)));
			if (state != src_fault_pkg::ST_ATTACHED || restartDone) begin
				voltageTarget <= src_fault_pkg::VSAFE_5V;
			end else if (voltageRequest > vmax) begin
				voltageTarget <= vmax;
			end else begin
				voltageTarget <= voltageRequest;
			end
		end
	end

	// Cable supply cut off without disconnecting, until hard reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cableSupplyOff <= 1'b0;
		end else if (cableSupplyOverCurrent) begin
			cableSupplyOff <= 1'b1;
		end else if (hardReset) begin
			cableSupplyOff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence resetEvent;
		softReset || hardReset;
	endsequence
	sequence capsOut;
		capsSend && selLatched == {$past(powerSelBit2, 2),
			$past(powerSelBit1, 2), $past(powerSelBit0, 2)};
	endsequence
	sequence recovery;
		restartDone ##1 (state == src_fault_pkg::ST_ATTACHED && reattach);
	endsequence

	AST_ADJ_DECODE: assert property (
		variant == src_fault_pkg::VAR_ADJUST && $stable(variant) &&
		$stable(selLatched) |=> advertisedPowerBudget ==
		src_fault_pkg::BUDGET_TABLE[$past(selLatched)])
		else $error("budget does not follow select code");
	AST_SMALL_FULL: assert property (
		variant == src_fault_pkg::VAR_SMALL |=>
		advertisedPowerBudget == src_fault_pkg::BUDGET_TABLE[3'h7])
		else $error("fixed variant not at full power");
	AST_LARGE_HALF: assert property (
		variant == src_fault_pkg::VAR_LARGE && selLatched[2] |=>
		advertisedPowerBudget == src_fault_pkg::BUDGET_TABLE[3'h3])
		else $error("top pin did not halve budget");
	AST_SAMPLE: assert property (
		powerOnDone and resetEvent |=> ##1 capsOut)
		else $error("reset did not resample pins");
	AST_RECOVER: assert property (
		recovery |=> capsSend)
		else $error("recovery did not resend capabilities");
	AST_DISCONNECT: assert property (
		protFault |=> !ccPullUpEn && !loadSwitchEn)
		else $error("fault left CC pull-up or switch on");
	AST_CABLE_ONLY: assert property (
		state == src_fault_pkg::ST_ATTACHED && faultPresent ==
		7'h40 |=> state == src_fault_pkg::ST_ATTACHED && cableSupplyOff)
		else $error("cable supply fault disconnected");
	AST_REATTACH: assert property (
		restartDone |=> voltageTarget == src_fault_pkg::VSAFE_5V ##1
		ccPullUpEn || protFault)
		else $error("reattach not at 5 V");
	AST_OV_DEBOUNCE: assert property (
		$rose(ovFault) |-> $past(ovRaw, 1) && ovCnt >= ovDebTerm)
		else $error("overvoltage raised before debounce");
	AST_BLANK: assert property (
		voltageTransition |=> !ovFault [*2])
		else $error("overvoltage not blanked");
	AST_CLAMP: assert property (
		state == src_fault_pkg::ST_ATTACHED && !restartDone |=>
		voltageTarget <= $past(vmax))
		else $error("target above limit");
	AST_UV_NO_ALERT: assert property (
		faultPresent == 7'h02 |=> !faultAlert)
		else $error("alert on undervoltage");
	AST_PPS_SUPPRESS: assert property (
		ppsContract && currentLimitActive |=> !uvFault && uvCnt == 16'h0)
		else $error("percentage trip under current limit");
	AST_UV_MIN: assert property (
		state == src_fault_pkg::ST_ATTACHED && vccBelowMin |=>
		state == src_fault_pkg::ST_FAULTED)
		else $error("minimum trip missed");
	AST_LATCH_HOLD: assert property (
		uvMinLatch && !vccBelowLatch |=> uvMinLatch && state !=
		src_fault_pkg::ST_ATTACHED)
		else $error("minimum trip released early");

endmodule // source_fault_and_power_select

// [sink_model.sv]
`timescale 1ns/1ps
module sink_model (
	input wire logic mclk,
	input wire logic ccPullUpEn,
	input wire logic capsSend,
	input wire logic [6:0] advertisedPowerBudget,
	output logic [6:0] heldBudget
);
	// ------------------------------------------------
	// Far-side view of the offer
	// ------------------------------------------------
	// Keeps the last offer while the source pull-up is present
	always_ff @(posedge mclk) begin
		if (!ccPullUpEn) begin
			heldBudget <= 7'h00;
		end else if (capsSend) begin
			heldBudget <= advertisedPowerBudget;
		end
	end
endmodule // sink_model

// [source_fault_and_power_select_bench.sv]
`timescale 1ns/1ps
module source_fault_and_power_select_bench;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic mclk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic powerSelBit0 = 0, powerSelBit1 = 0, powerSelBit2 = 0;
	logic softReset = 0, hardReset = 0, vccBelowMin = 0, vccBelowLatch = 0;
	logic cableSupplyOverCurrent = 0, voltageTransition = 0;
	logic ppsContract = 0, currentLimitActive = 0;
	logic [5:0] flt = 6'h00; // Fault lines, one hot
	wire overCurrent, intOverTemp, ccPinOverVoltage, vccAboveOvp;
	wire vccBelowUvp, thermistorOverTemp;
	logic [15:0] voltageRequest = 16'h01f4, voltageTarget;
	logic [6:0] advertisedPowerBudget, heldBudget;
	logic [8:0] pdoCurrent5v, pdoCurrent9v, pdoCurrent12v, pdoCurrent15v;
	logic [8:0] pdoCurrent20v;
	logic ack_o, capsSend, ccPullUpEn, loadSwitchEn, reattach, faultAlert;
	logic cableSupplyOff;
	int mismatches = 0, tests_run = 0;
	// Budget in half watts, 20 V current in 10 mA, by code
	logic [6:0] bud [0:7] = '{7'h20, 7'h20, 7'h2d, 7'h3c, 7'h4b, 7'h5a,
		7'h69, 7'h78};
	logic [8:0] cur20 [0:7] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000,
		9'h0e1, 9'h104, 9'h12c};
	assign {thermistorOverTemp, vccBelowUvp, vccAboveOvp, ccPinOverVoltage,
		intOverTemp, overCurrent} = flt;

	source_fault_and_power_select #(.RESTART_CYCLES(32'h14))
		source_fault_and_power_select_i (.*);
	sink_model sink_model_i (.*);

	initial begin
		forever #20 mclk = ~mclk;
	end

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Waits for a level under a bound, then compares it
	task automatic wt(ref logic s, input logic v, input int lim);
		int n = 0;
		do @(posedge mclk); while (s !== v && ++n < lim);
		chk(s, v);
	endtask
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge mclk); while (ack_o !== 1'b1 && ++n < 50);
		chk(ack_o, 1'b1);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
	endtask
	// Sets the select code and resends the offer
	task automatic caps(input logic [2:0] c);
		@(posedge mclk);
		{powerSelBit2, powerSelBit1, powerSelBit0} <= c;
		softReset <= c[0];
		hardReset <= !c[0];
		@(posedge mclk);
		softReset <= 0;
		hardReset <= 0;
		wt(capsSend, 1, 5);
	endtask
	task automatic trip(input int k, input logic al);
		@(posedge mclk);
		flt <= 6'(1 << k);
		wt(ccPullUpEn, 0, 1000);
		chk(faultAlert, al);
		chk(loadSwitchEn, 0);
		flt <= 6'h00;
		wt(reattach, 1, 100);
		chk(voltageTarget, 16'h01f4);
		wt(capsSend, 1, 3);
		wt(ccPullUpEn, 1, 5);
		$display("fault %0d test done", k);
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic test_select();
		for (int c = 0; c < 8; c++) begin
			logic [44:0] t;
			t = src_fault_pkg::CUR_TABLE[c];
			caps(3'(c));
			chk(advertisedPowerBudget, bud[c]);
			chk(pdoCurrent20v, cur20[c]);
			chk({pdoCurrent5v, pdoCurrent9v}, 32'(t[44:27]));
			chk({pdoCurrent12v, pdoCurrent15v}, 32'(t[26:9]));
			@(posedge mclk);
			chk(heldBudget, bud[c]);
		end
		{powerSelBit2, powerSelBit1, powerSelBit0} <= 3'h0;
		repeat (4) @(posedge mclk);
		chk(advertisedPowerBudget, bud[7]);
		$display("select test done");
	endtask
	task automatic test_variant();
		wb(1, src_fault_pkg::REG_VARIANT, 32'h2);
		caps(3'h4);
		chk(advertisedPowerBudget, bud[3]);
		caps(3'h3);
		chk(advertisedPowerBudget, bud[7]);
		{powerSelBit2, powerSelBit1, powerSelBit0} <= 3'h4;
		trip(5, 1);
		chk(advertisedPowerBudget, bud[3]);
		wb(1, src_fault_pkg::REG_VARIANT, 32'h1);
		caps(3'h0);
		chk(advertisedPowerBudget, bud[7]);
		wb(0, src_fault_pkg::REG_VARIANT, 32'h0);
		chk(rd, 32'h1);
		wb(1, src_fault_pkg::REG_VARIANT, 32'h0);
		wb(0, 5'h02, 32'h0);
		chk(rd, 32'h0);
		$display("variant test done");
	endtask
	task automatic test_min();
		@(posedge mclk);
		vccBelowMin <= 1;
		wt(ccPullUpEn, 0, 3);
		chk(faultAlert, 0);
		vccBelowMin <= 0;
		repeat (40) @(posedge mclk);
		chk(ccPullUpEn, 0);
		vccBelowLatch <= 1;
		wt(reattach, 1, 100);
		vccBelowLatch <= 0;
		ppsContract <= 1;
		currentLimitActive <= 1;
		flt <= 6'h10;
		repeat (900) @(posedge mclk);
		chk(ccPullUpEn, 1);
		flt <= 6'h00;
		ppsContract <= 0;
		currentLimitActive <= 0;
		$display("minimum test done");
	endtask
	// Overvoltage held well past debounce inside the blanking window
	task automatic test_blank();
		@(posedge mclk);
		voltageTransition <= 1;
		voltageRequest <= 16'h0900;
		@(posedge mclk);
		voltageTransition <= 0;
		flt <= 6'h08;
		repeat (900) @(posedge mclk);
		chk(ccPullUpEn, 1);
		chk(voltageTarget, 32'(src_fault_pkg::VMAX_RST));
		flt <= 6'h00;
		voltageRequest <= 16'h01f4;
		$display("blank test done");
	endtask
	task automatic test_cable();
		@(posedge mclk);
		cableSupplyOverCurrent <= 1;
		wt(cableSupplyOff, 1, 5);
		chk(ccPullUpEn, 1);
		cableSupplyOverCurrent <= 0;
		hardReset <= 1;
		@(posedge mclk);
		hardReset <= 0;
		wt(cableSupplyOff, 0, 5);
		wb(0, src_fault_pkg::REG_HIST, 32'h0);
		chk(rd, 32'h7f);
		wb(1, src_fault_pkg::REG_HIST, 32'h7f);
		wb(0, src_fault_pkg::REG_HIST, 32'h0);
		chk(rd, 32'h0);
		$display("cable test done");
	endtask

	task automatic give_verdict();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#3000000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		repeat (3) @(posedge mclk);
		test_select();
		test_variant();
		for (int k = 0; k < 5; k++) trip(k, k != 4);
		test_min();
		test_blank();
		test_cable();
		give_verdict();
	end
endmodule // source_fault_and_power_select_bench
